// File: hw/dma_chan_defs.vh
// register offsets, field positions and widths for the dma channel block
`ifndef DMA_CHAN_DEFS_VH
`define DMA_CHAN_DEFS_VH
`define OFS_CONTROL 12'h000
`define OFS_LENGTH 12'h004
`define OFS_PRIMARY 12'h008
`define OFS_SECONDARY 12'h00C
`define OFS_REQSEL 12'h010
`define OFS_STATUS 12'h014
`define OFS_INT_STATUS 12'h018
`define OFS_INT_MASK 12'h01C
`define OFS_ADDR 12'h020
`define CTL_MODE_LO 0
`define CTL_MODE_HI 1
`define CTL_HALF 2
`define CTL_ENABLE 3
`define REQ_MANUAL 8
`define ST_RAM_COL 0
`define ST_PER_COL 1
`define ST_ACTIVE_BUF 2
`define INT_CHAN 0
`define INT_COL 1
`define INT_DONE 2
`define LEN_W 10
`define ADDR_W 11
`define SEL_W 7
`endif

// File: hw/dma_req_sync.v
// two-flip-flop synchroniser with rising edge pulse for peripheral requests
`timescale 1ns/1ns
`default_nettype none
module dma_req_sync #(
  parameter N = 4
) (
  input wire pclk,
  input wire presetn,
  input wire [N-1:0] async_in,
  output wire [N-1:0] rise
);
  reg [N-1:0] meta;
  reg [N-1:0] sync;
  reg [N-1:0] last;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= {N{1'b0}};
      sync <= {N{1'b0}};
      last <= {N{1'b0}};
    end
    else
    begin
      meta <= async_in;
      sync <= meta;
      last <= sync;
    end
  end
  assign rise = sync & ~last;
endmodule
`default_nettype wire

// File: hw/dma_channel.v
// one dma channel: block sequencing, ping-pong, manual request, apb registers
//
// Overview of operation
// RULE_01: mode low bit one selects one-shot, high bit ignored for that choice.
// RULE_02: one-shot clears the enable bit itself after the full block.
// RULE_03: one-shot with half selected flags at half point, not at end.
// RULE_04: re-enabling after one-shot restarts from the start offset.
// RULE_05: continuous keeps enable; address returns to primary on last transfer.
// RULE_06: continuous with half flags only at half point, stays enabled.
// RULE_07: enabling selects primary; non ping-pong blocks restart from primary.
// RULE_08: mode high bit selects ping-pong between primary and secondary offsets.
// RULE_09: continuous ping-pong alternates buffers forever, flag after each.
// RULE_10: one-shot ping-pong does primary, then secondary, then disables.
// RULE_11: manual request bit forces one element like a peripheral request.
// RULE_12: software zero does not clear manual bit; hardware clears it after.
// RULE_13: setting manual bit during a transfer in progress is ignored.
// RULE_14: software should not set manual bit in the configuring write.
// RULE_15: manual with pending peripheral request drops forced, sets both collisions.
// RULE_16: one request source may be selected by several channels.
// RULE_17: disable then enable resets count to zero and primary active.
// RULE_18: length register holds transfers minus one.
// RULE_19: address post-increments; active buffer toggles at each block end; code toggles it only in ping-pong, else it stays primary.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "dma_chan_defs.vh"
module dma_channel #(
  parameter NREQ = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [NREQ-1:0] periph_req,
  output reg ram_we,
  output reg [`ADDR_W-1:0] ram_addr,
  output wire irq
);
  localparam S_IDLE = 2'b01;
  localparam S_XFER = 2'b10;

  reg [1:0] state;
  reg [1:0] mode;
  reg half_sel;
  reg channel_enable_bit;
  reg [`LEN_W-1:0] block_length_reg;
  reg [`ADDR_W-1:0] primary_start_offset_reg;
  reg [`ADDR_W-1:0] secondary_start_offset_reg;
  reg [`SEL_W-1:0] req_source;
  reg manual_req;
  reg ram_write_collision_flag;
  reg periph_write_collision_flag;
  reg [2:0] int_status;
  reg [2:0] int_mask;
  reg [`LEN_W-1:0] count;
  reg active_secondary;
  reg [`ADDR_W-1:0] cur_addr;

  wire [NREQ-1:0] req_rise;
  wire wr;
  wire rd;
  wire one_shot;
  wire ping_pong;
  wire periph_hit;
  wire manual_set_try;
  wire service;
  wire last;
  wire half_point;
  reg ev_chan;
  reg ev_col;
  reg ev_done;
  wire [`ADDR_W-1:0] next_block_start;
  wire [NREQ-1:0] src_match;
  wire ctl_wr;
  wire enable_rise;
  wire xfer;
  wire manual_ok;
  wire int_clr_wr;
  reg next_enable;
  reg next_active;
  reg [`LEN_W-1:0] next_count;
  reg [`ADDR_W-1:0] next_addr;

  // one synchroniser per channel, so any channel can share a source [RULE_16]
  dma_req_sync #(.N(NREQ)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(periph_req),
    .rise(req_rise)
  );

  function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  assign wr = psel & penable & pwrite;
  assign rd = psel & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  assign one_shot = mode[0]; // [RULE_01]
  assign ping_pong = mode[1]; // [RULE_08]
  // one comparator per request line, so any NREQ up to 128 works
  genvar g;
  generate
    for (g = 0; g < NREQ; g = g + 1)
    begin : g_src
      assign src_match[g] = (req_source == g) & req_rise[g];
    end
  endgenerate
  assign periph_hit = |src_match;
  assign manual_set_try = wr & hit(paddr, `OFS_REQSEL) & pwdata[`REQ_MANUAL];
  // a peripheral request wins over the forced one [RULE_15]
  assign service = channel_enable_bit & (state == S_IDLE) & (periph_hit | (manual_req & ~periph_hit));
  assign last = (count == block_length_reg); // [RULE_18]
  assign half_point = (count == (block_length_reg >> 1));
  // alternate start only in ping-pong, else always primary [RULE_07] [RULE_19]
  assign next_block_start = (ping_pong & ~active_secondary) ? secondary_start_offset_reg : primary_start_offset_reg;

  assign ctl_wr = wr & hit(paddr, `OFS_CONTROL);
  assign enable_rise = ctl_wr & pwdata[`CTL_ENABLE] & ~channel_enable_bit;
  assign xfer = (state == S_XFER);
  assign int_clr_wr = wr & hit(paddr, `OFS_INT_STATUS);
  // busy channel drops the attempt, a disabled one never takes it [RULE_13]
  assign manual_ok = manual_set_try & channel_enable_bit & ~xfer;

  // software configuration registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode <= 2'b00;
      half_sel <= 1'b0;
      block_length_reg <= {`LEN_W{1'b0}};
      primary_start_offset_reg <= {`ADDR_W{1'b0}};
      secondary_start_offset_reg <= {`ADDR_W{1'b0}};
      req_source <= {`SEL_W{1'b0}};
      int_mask <= 3'h0;
    end
    else
    begin
      if (ctl_wr)
      begin
        mode <= pwdata[`CTL_MODE_HI:`CTL_MODE_LO];
        half_sel <= pwdata[`CTL_HALF];
      end
      if (wr & hit(paddr, `OFS_LENGTH))
        block_length_reg <= pwdata[`LEN_W-1:0];
      if (wr & hit(paddr, `OFS_PRIMARY))
        primary_start_offset_reg <= pwdata[`ADDR_W-1:0];
      if (wr & hit(paddr, `OFS_SECONDARY))
        secondary_start_offset_reg <= pwdata[`ADDR_W-1:0];
      if (wr & hit(paddr, `OFS_REQSEL))
        req_source <= pwdata[`SEL_W-1:0];
      if (wr & hit(paddr, `OFS_INT_MASK))
        int_mask <= pwdata[2:0];
    end
  end

  // hardware stop wins over a software write in the same cycle
  always @*
  begin
    next_enable = channel_enable_bit;
    if (ctl_wr)
      next_enable = pwdata[`CTL_ENABLE];
    // one-shot ping-pong stops after the secondary block [RULE_10]
    if (xfer & last & one_shot & (~ping_pong | active_secondary))
      next_enable = 1'b0; // [RULE_02]
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      channel_enable_bit <= 1'b0;
    else
      channel_enable_bit <= next_enable;
  end

  always @*
  begin
    next_count = count;
    next_addr = cur_addr;
    next_active = active_secondary;
    if (enable_rise)
    begin
      next_count = {`LEN_W{1'b0}}; // [RULE_17]
      next_active = 1'b0; // [RULE_07]
      next_addr = primary_start_offset_reg; // [RULE_04]
    end
    if (xfer)
    begin
      if (last)
      begin
        next_count = {`LEN_W{1'b0}};
        next_active = ping_pong & ~active_secondary; // [RULE_19]
        next_addr = next_block_start; // [RULE_05] [RULE_08]
      end
      else
      begin
        next_count = count + 1'b1;
        next_addr = cur_addr + 1'b1; // [RULE_19]
      end
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= {`LEN_W{1'b0}};
      active_secondary <= 1'b0;
      cur_addr <= {`ADDR_W{1'b0}};
    end
    else
    begin
      count <= next_count;
      active_secondary <= next_active;
      cur_addr <= next_addr;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= S_IDLE;
    else
    begin
      case (state)
        S_IDLE:
        begin
          if (service)
            state <= S_XFER;
        end
        S_XFER:
          state <= S_IDLE;
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // manual bit: only set by software, never cleared by a zero write [RULE_12]
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      manual_req <= 1'b0;
    else if (xfer)
      manual_req <= 1'b0; // [RULE_12]
    else if (manual_ok & ~periph_hit)
      manual_req <= 1'b1; // [RULE_11]
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ram_write_collision_flag <= 1'b0;
      periph_write_collision_flag <= 1'b0;
    end
    else if (manual_ok & periph_hit)
    begin
      ram_write_collision_flag <= 1'b1; // [RULE_15]
      periph_write_collision_flag <= 1'b1; // [RULE_15]
    end
    else if (wr & hit(paddr, `OFS_STATUS))
    begin
      if (pwdata[`ST_RAM_COL])
        ram_write_collision_flag <= 1'b0;
      if (pwdata[`ST_PER_COL])
        periph_write_collision_flag <= 1'b0;
    end
  end

  // address only moves with a write strobe, so the ram sees a clean pair
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ram_we <= 1'b0;
      ram_addr <= {`ADDR_W{1'b0}};
    end
    else
    begin
      ram_we <= xfer; // [RULE_11]
      if (xfer)
        ram_addr <= cur_addr;
    end
  end

  always @*
  begin
    ev_chan = 1'b0;
    ev_col = 1'b0;
    ev_done = 1'b0;
    if (manual_ok & periph_hit)
      ev_col = 1'b1; // [RULE_15]
    if (xfer)
    begin
      if (half_sel & half_point)
        ev_chan = 1'b1; // [RULE_03] [RULE_06]
      if (last)
      begin
        ev_done = 1'b1;
        if (~half_sel)
          ev_chan = 1'b1; // [RULE_09]
      end
    end
  end

  // a new event beats a clear in the same cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_status <= 3'h0;
    else
      int_status <= (int_clr_wr ? (int_status & ~pwdata[2:0]) : int_status)
        | {ev_done, ev_col, ev_chan};
  end

  assign irq = |(int_status & int_mask);

  always @*
  begin
    prdata = 32'h00000000;
    if (rd)
    begin
      if (hit(paddr, `OFS_CONTROL))
        prdata = {28'h0000000, channel_enable_bit, half_sel, mode};
      else if (hit(paddr, `OFS_LENGTH))
        prdata = {22'h000000, block_length_reg};
      else if (hit(paddr, `OFS_PRIMARY))
        prdata = {21'h000000, primary_start_offset_reg};
      else if (hit(paddr, `OFS_SECONDARY))
        prdata = {21'h000000, secondary_start_offset_reg};
      else if (hit(paddr, `OFS_REQSEL))
        prdata = {23'h000000, manual_req, 1'b0, req_source};
      else if (hit(paddr, `OFS_STATUS))
        prdata = {29'h00000000, active_secondary, periph_write_collision_flag, ram_write_collision_flag};
      else if (hit(paddr, `OFS_INT_STATUS))
        prdata = {29'h00000000, int_status};
      else if (hit(paddr, `OFS_INT_MASK))
        prdata = {29'h00000000, int_mask};
      else if (hit(paddr, `OFS_ADDR))
        prdata = {11'h000, count, cur_addr};
    end
  end
endmodule
`default_nettype wire

// File: testbench/dma_channel_properties.sv
// port assertions for the dma channel
`timescale 1ns/1ns
`default_nettype none
`include "dma_chan_defs.vh"
module dma_channel_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ram_we,
  input wire logic [`ADDR_W-1:0] ram_addr,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pwrite;
  a_ready_high: assert property (psel |-> pready) else $error("pready low");
  a_no_slverr: assert property (!pslverr) else $error("pslverr high");
  a_we_single: assert property (ram_we |=> !ram_we) else $error("ram_we too long");
  a_rdata_idle: assert property ((!psel || pwrite) |-> prdata == 32'h0) else $error("prdata not zero");
  a_unmapped_zero: assert property ((psel && !pwrite && paddr > `OFS_ADDR) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($rose(presetn) |-> !ram_we && !irq) else $error("busy after reset");
  a_addr_hold: assert property ($changed(ram_addr) |-> ram_we || $past(acc)) else $error("ram_addr moved");
  a_irq_masked: assert property ((acc && paddr == `OFS_INT_MASK && pwdata == 32'h0) |=> !irq)
    else $error("irq while masked");
endmodule
bind dma_channel dma_channel_properties u_dma_channel_properties (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ram_we(ram_we), .ram_addr(ram_addr), .irq(irq));
`default_nettype wire

// File: testbench/periph_model.sv
// peripheral request source: stretches fire pulses into request levels
`timescale 1ns/1ns
`default_nettype none
module periph_model (
  input wire logic pclk,
  input wire logic [3:0] fire,
  output logic [3:0] periph_req
);
  logic [2:0] hold = 3'h0;
  initial periph_req = 4'h0;
  // held long enough to cross the two-stage synchroniser
  always @(posedge pclk)
  begin
    if (|fire)
    begin
      periph_req <= periph_req | fire;
      hold <= 3'h4;
    end
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
    else
      periph_req <= 4'h0;
  end
endmodule
`default_nettype wire

// File: testbench/tb_dma_channel.sv
// self-checking bench for the dma channel
`timescale 1ns/1ns
`default_nettype none
`include "dma_chan_defs.vh"
module tb_dma_channel;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] fire = 4'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [3:0] periph_req;
  wire ram_we;
  wire [`ADDR_W-1:0] ram_addr;
  wire irq;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int we_cnt = 0;
  int n;
  logic [31:0] r;
  logic [31:0] e;
  typedef struct {logic [3:0] ctl; int len; int nreq; logic en; logic flag;} row_t;
  row_t rows [7] = '{'{4'h1, 3, 4, 1'b0, 1'b1}, '{4'h3, 1, 4, 1'b0, 1'b1}, '{4'h0, 2, 4, 1'b1, 1'b1},
    '{4'h2, 1, 6, 1'b1, 1'b1}, '{4'h5, 3, 3, 1'b1, 1'b1}, '{4'h1, 3, 3, 1'b1, 1'b0}, '{4'h4, 3, 3, 1'b1, 1'b1}};
  always #20 pclk = ~pclk;
  dma_channel #(.NREQ(4)) u_dma_channel (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_req(periph_req), .ram_we(ram_we), .ram_addr(ram_addr), .irq(irq));
  periph_model u_periph_model (.pclk(pclk), .fire(fire), .periph_req(periph_req));
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x)
    begin
      error_cnt++;
      $display("Error at %0t: got %h want %h", $time, g, x);
    end
  endtask
  // last low keeps psel up so the next setup follows at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic last);
    if (psel !== 1'b1)
      psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    penable <= 1'b0;
    if (last)
    begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b1);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0, 1'b1);
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (ram_we === 1'b1)
      we_cnt++;
    if (cyc == 5000)
    begin
      error_cnt++;
      final_report();
    end
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 17; i++)
    begin
      rd(12'(i * 4));
      chk(r, 32'h0);
    end
    $display("reset and unmapped reads done");
    wr(`OFS_PRIMARY, 32'h100);
    wr(`OFS_SECONDARY, 32'h200);
    wr(`OFS_INT_MASK, 32'h1);
    foreach (rows[i])
    begin
      wr(`OFS_CONTROL, {28'h0, rows[i].ctl});
      wr(`OFS_LENGTH, rows[i].len);
      wr(`OFS_INT_STATUS, 32'h7);
      wr(`OFS_CONTROL, {28'h0, rows[i].ctl} | 32'h8);
      for (int k = 0; k < rows[i].nreq; k++)
      begin
        wr(`OFS_REQSEL, 32'h103);
        do @(posedge pclk); while (ram_we !== 1'b1);
        e = (rows[i].ctl[1] && (k / (rows[i].len + 1)) % 2) ? 32'h200 : 32'h100;
        chk({21'h0, ram_addr}, e + k % (rows[i].len + 1));
      end
      rd(`OFS_CONTROL);
      chk(r[3], rows[i].en);
      rd(`OFS_INT_STATUS);
      chk(r[0], rows[i].flag);
      $display("row %0d done", i);
    end
    chk(irq, 1'b1);
    wr(`OFS_INT_MASK, 32'h0);
    chk(irq, 1'b0);
    wr(`OFS_INT_MASK, 32'h1);
    chk(irq, 1'b1);
    wr(`OFS_INT_STATUS, 32'h1);
    chk(irq, 1'b0);
    $display("interrupt test done");
    n = we_cnt;
    apb(1'b1, `OFS_REQSEL, 32'h103, 1'b0);
    apb(1'b1, `OFS_REQSEL, 32'h103, 1'b0);
    apb(1'b1, `OFS_REQSEL, 32'h003, 1'b1);
    repeat (12) @(posedge pclk);
    chk(we_cnt - n, 1);
    $display("manual overlap test done");
    wr(`OFS_REQSEL, 32'h2);
    n = we_cnt;
    fire <= 4'h4;
    @(posedge pclk);
    fire <= 4'h2;
    @(posedge pclk);
    fire <= 4'h0;
    repeat (12) @(posedge pclk);
    chk(we_cnt - n, 1);
    $display("peripheral request test done");
    // manual write lands on the edge where the selected request is seen
    fire <= 4'h4;
    @(posedge pclk);
    fire <= 4'h0;
    @(posedge pclk);
    n = we_cnt;
    apb(1'b1, `OFS_REQSEL, 32'h102, 1'b1);
    repeat (8) @(posedge pclk);
    chk(we_cnt - n, 1);
    rd(`OFS_STATUS);
    chk(r[1:0], 2'b11);
    rd(`OFS_REQSEL);
    chk(r[8], 1'b0);
    wr(`OFS_STATUS, 32'h3);
    rd(`OFS_STATUS);
    chk(r[1:0], 2'b00);
    $display("collision test done");
    wr(`OFS_INT_MASK, 32'h7);
    chk(irq, 1'b1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(irq, 1'b0);
    rd(`OFS_CONTROL);
    chk(r, 32'h0);
    $display("mid-run reset test done");
    final_report();
  end
endmodule
`default_nettype wire
